//--- inc/gpio_port_defs.vh
// Offsets, field positions, reset values and timing counts for the port pin block
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// Register byte offsets on the Avalon-MM slave
`define OFS_PORT_E_PIN_LEVELS    4'h0
`define OFS_PORT_E_OUTPUT_LATCH  4'h1
`define OFS_PORT_E_DIRECTION     4'h2
`define OFS_PORT_F_PIN_LEVELS    4'h3
`define OFS_PORT_F_OUTPUT_LATCH  4'h4
`define OFS_PORT_F_DIRECTION     4'h5
`define OFS_ANALOG_CONFIG        4'h6
`define OFS_COMPARATOR_CONTROL   4'h7
`define OFS_MUX_CONTROL          4'h8

// Reset values
`define RST_DIRECTION            8'hff
`define RST_LATCH                8'h00
`define RST_ANALOG_CONFIG        8'h00
`define RST_COMPARATOR_CONTROL   8'h07
`define RST_MUX_CONTROL          8'h00

// Analog configuration: pins 6..0 are digital once the field reaches this value
`define ANALOG_FIELD_LSB         0
`define ANALOG_FIELD_MSB         3
`define ANALOG_ALL_DIGITAL       4'hf
`define ANALOG_PIN_MASK          8'h7f

// Comparator control fields
`define CMP_MODE_MSB             2
`define CMP_MODE_LSB             0
`define CMP_MODE_OFF             3'h7
`define CMP_MODE_OUTPUTS         3'h6

// Mux control fields
`define MUX_EXT_MEM_ENABLE       0
`define MUX_CAPTURE_PIN_SELECT   1
`define MUX_PWM1_ENABLE          2
`define MUX_PWM1_TRISTATE        3
`define MUX_CAPTURE_ENABLE       4
`define MUX_PWM2_ENABLE          5
`define MUX_PWM2_TRISTATE        6

// Wait states before an access completes
`define ACCESS_WAIT_CYCLES       2'h1

`endif

//--- verilog/gpio_pin_cell.v
// One output stage and input gate for a single port pin
`timescale 1ns/1ns
`default_nettype none

module gpio_pin_cell (
	input  wire	clk_sys,
	input  wire	resetn,
	input  wire	drive_req,
	input  wire	drive_val,
	input  wire	pin_in,
	input  wire	in_gate,
	output reg	pin_out,
	output reg	pin_oe,
	output reg	pin_level_q
);

	////////////////////////////////////////////////////////////////////////
	// Register the driver and the gated input level
	always @(posedge clk_sys) begin
		if (!resetn) begin
			pin_out     <= 1'b0;
			pin_oe      <= 1'b0;
			pin_level_q <= 1'b0;
		end else begin
			pin_out     <= drive_val;
			pin_oe      <= drive_req;
			pin_level_q <= pin_in & in_gate;
		end
	end

endmodule // gpio_pin_cell

`default_nettype wire

//--- verilog/gpio_port_pin_mux_logic.v
// Port E upper pins and port F pin logic with an Avalon-MM register slave
// How it works
// RULE1 - Port F direction one: pin is input, driver off.
// RULE2 - Port F direction zero: pin driven from the output latch.
// RULE3 - Port F latch is mapped; reading it returns latch, not pins.
// RULE4 - Port F has eight pins, each with its own direction bit.
// RULE5 - After reset port F pins 6..0 are analog and read zero.
// RULE6 - Digital input on pins 6..0 passes only once analog selection is off.
// RULE7 - Port F pins 1 and 2 carry comparator outputs when selected.
// RULE8 - Active external memory drives bits 13..15 on port E pins 5..7.
// RULE9 - External memory reads sample bits 13..15 from port E pins 5..7.
// RULE10 - External memory function exists only in the larger package.
// RULE11 - PWM unit one channels C and B on pins 5 and 6, tri-state option.
// RULE12 - Pin 7 carries unit two compare out, or its capture input.
// RULE13 - Unit two maps to pin 7 only when pin select is cleared.
// RULE14 - Under that mapping PWM two channel A on pin 7, tri-state option.
// RULE15 - Port E registers behave per bit like port F.
// RULE16 - Priority: external memory, then PWM or compare, then latch.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_defs.vh"

module gpio_port_pin_mux_logic #(
	parameter LARGE_PACKAGE = 1
) (
	input  wire		clk_sys,
	input  wire		resetn,
	// Avalon-MM slave
	input  wire [3:0]	avs_address,
	input  wire		avs_read,
	input  wire		avs_write,
	input  wire [31:0]	avs_writedata,
	input  wire [3:0]	avs_byteenable,
	output reg  [31:0]	avs_readdata,
	output reg		avs_waitrequest,
	output reg  [1:0]	avs_response,
	// Port E pins 7..5 (index 0 is pin 5)
	input  wire [2:0]	port_e_pin_in,
	output wire [2:0]	port_e_pin_out,
	output wire [2:0]	port_e_pin_oe,
	// Port F pins
	input  wire [7:0]	port_f_pin_in,
	output wire [7:0]	port_f_pin_out,
	output wire [7:0]	port_f_pin_oe,
	// External memory bus
	input  wire		ext_mem_active,
	input  wire		ext_mem_read,
	input  wire [2:0]	ext_mem_addr_data_out,
	output reg  [2:0]	ext_mem_addr_data_in,
	// PWM and capture peripherals
	input  wire		pwm_one_channel_c,
	input  wire		pwm_one_channel_b,
	input  wire		pwm_one_shutdown,
	input  wire		capture_unit_two_out,
	input  wire		pwm_two_channel_a,
	input  wire		pwm_two_shutdown,
	output reg		capture_unit_two_in,
	// Comparator outputs
	input  wire		comparator_one_out,
	input  wire		comparator_two_out
);

	////////////////////////////////////////////////////////////////////////
	// Registers
	reg  [7:0]	port_e_output_latch_q;
	reg  [7:0]	port_e_direction_q;
	reg  [7:0]	port_f_output_latch_q;
	reg  [7:0]	port_f_direction_q;
	reg  [7:0]	analog_configuration_q;
	reg  [7:0]	comparator_control_q;
	reg  [7:0]	mux_control_q;
	reg  [1:0]	wait_cnt_q;
	wire [2:0]	port_e_level;
	wire [7:0]	port_f_level;

	// Merge a byte write under its lane enable
	function [7:0] merge_byte;
		input [7:0] old_val;
		input [7:0] new_val;
		input       lane_en;
		begin
			merge_byte = lane_en ? new_val : old_val;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Derived mux controls
	wire ext_mem_on = (LARGE_PACKAGE != 0) & ext_mem_active & mux_control_q[`MUX_EXT_MEM_ENABLE]; // [RULE10]
	wire cap_on_e7  = ~mux_control_q[`MUX_CAPTURE_PIN_SELECT]; // [RULE13]
	wire all_digital = (analog_configuration_q[`ANALOG_FIELD_MSB:`ANALOG_FIELD_LSB] == `ANALOG_ALL_DIGITAL);
	wire [2:0] cmp_mode = comparator_control_q[`CMP_MODE_MSB:`CMP_MODE_LSB];
	wire cmp_outputs = (cmp_mode == `CMP_MODE_OUTPUTS);

	////////////////////////////////////////////////////////////////////////
	// Port E pin 5..7 output selection
	reg [2:0] e_drive;
	reg [2:0] e_val;
	reg       pwm_cap_sel;
	always @* begin
		e_drive = ~port_e_direction_q[7:5]; // [RULE15]
		e_val   = port_e_output_latch_q[7:5];
		// PWM unit one on pins 5 and 6 with direction zero
		if (mux_control_q[`MUX_PWM1_ENABLE]) begin // [RULE11]
			e_val[0] = pwm_one_channel_c;
			e_val[1] = pwm_one_channel_b;
			if (pwm_one_shutdown && mux_control_q[`MUX_PWM1_TRISTATE])
				e_drive[1:0] = 2'h0;
		end
		// Pin 7: compare output or enhanced channel A
		pwm_cap_sel = cap_on_e7 & mux_control_q[`MUX_CAPTURE_ENABLE];
		if (pwm_cap_sel) begin // [RULE12]
			if (mux_control_q[`MUX_PWM2_ENABLE]) begin // [RULE14]
				e_val[2] = pwm_two_channel_a;
				if (pwm_two_shutdown && mux_control_q[`MUX_PWM2_TRISTATE])
					e_drive[2] = 1'b0;
			end else begin
				e_val[2] = capture_unit_two_out;
			end
		end
		// External memory overrides everything
		if (ext_mem_on) begin // [RULE8] [RULE16]
			e_drive = {3{~ext_mem_read}};
			e_val   = ext_mem_addr_data_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port F output selection and input gate
	reg [7:0] f_drive;
	reg [7:0] f_val;
	reg [7:0] f_gate;
	always @* begin
		f_drive = ~port_f_direction_q; // [RULE1] [RULE2] [RULE4]
		f_val   = port_f_output_latch_q;
		if (cmp_outputs) begin // [RULE7]
			f_val[1] = comparator_two_out;
			f_val[2] = comparator_one_out;
		end
		f_gate = all_digital ? 8'hff : ~`ANALOG_PIN_MASK; // [RULE5] [RULE6]
	end

	////////////////////////////////////////////////////////////////////////
	// Pin cells
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_e
			gpio_pin_cell u_cell (
				.clk_sys	(clk_sys),
				.resetn		(resetn),
				.drive_req	(e_drive[gi]),
				.drive_val	(e_val[gi]),
				.pin_in		(port_e_pin_in[gi]),
				.in_gate	(1'b1),
				.pin_out	(port_e_pin_out[gi]),
				.pin_oe		(port_e_pin_oe[gi]),
				.pin_level_q	(port_e_level[gi])
			);
		end
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_f
			gpio_pin_cell u_cell (
				.clk_sys	(clk_sys),
				.resetn		(resetn),
				.drive_req	(f_drive[gi]),
				.drive_val	(f_val[gi]),
				.pin_in		(port_f_pin_in[gi]),
				.in_gate	(f_gate[gi]),
				.pin_out	(port_f_pin_out[gi]),
				.pin_oe		(port_f_pin_oe[gi]),
				.pin_level_q	(port_f_level[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Peripheral inputs from port E
	always @(posedge clk_sys) begin
		if (!resetn) begin
			ext_mem_addr_data_in <= 3'h0;
			capture_unit_two_in  <= 1'b0;
		end else begin
			if (ext_mem_on && ext_mem_read)
				ext_mem_addr_data_in <= port_e_pin_in; // [RULE9]
			capture_unit_two_in <= pwm_cap_sel & port_e_direction_q[7] & port_e_pin_in[2]; // [RULE12]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, then the access completes
	wire access = avs_read | avs_write;
	wire done   = access & (wait_cnt_q == `ACCESS_WAIT_CYCLES);
	wire mapped = (avs_address <= `OFS_MUX_CONTROL);
	wire [7:0] pe_levels = {port_e_level, 5'h00};
	reg  [7:0] rd_byte;
	always @* begin
		case (avs_address)
		`OFS_PORT_E_PIN_LEVELS:   rd_byte = pe_levels;
		`OFS_PORT_E_OUTPUT_LATCH: rd_byte = port_e_output_latch_q;
		`OFS_PORT_E_DIRECTION:    rd_byte = port_e_direction_q;
		`OFS_PORT_F_PIN_LEVELS:   rd_byte = port_f_level;
		`OFS_PORT_F_OUTPUT_LATCH: rd_byte = port_f_output_latch_q; // [RULE3]
		`OFS_PORT_F_DIRECTION:    rd_byte = port_f_direction_q;
		`OFS_ANALOG_CONFIG:       rd_byte = analog_configuration_q;
		`OFS_COMPARATOR_CONTROL:  rd_byte = comparator_control_q;
		`OFS_MUX_CONTROL:         rd_byte = mux_control_q;
		default:                  rd_byte = 8'h00;
		endcase
	end

	// Wait counter, readback and register writes
	always @(posedge clk_sys) begin
		if (!resetn) begin
			wait_cnt_q             <= 2'h0;
			avs_waitrequest        <= 1'b1;
			avs_readdata           <= 32'h0;
			avs_response           <= 2'h0;
			port_e_output_latch_q  <= `RST_LATCH;
			port_e_direction_q     <= `RST_DIRECTION;
			port_f_output_latch_q  <= `RST_LATCH;
			port_f_direction_q     <= `RST_DIRECTION;
			analog_configuration_q <= `RST_ANALOG_CONFIG;
			comparator_control_q   <= `RST_COMPARATOR_CONTROL;
			mux_control_q          <= `RST_MUX_CONTROL;
		end else begin
			avs_waitrequest <= ~(access & (wait_cnt_q + 2'h1 == `ACCESS_WAIT_CYCLES) & ~done);
			if (done || !access)
				wait_cnt_q <= 2'h0;
			else
				wait_cnt_q <= wait_cnt_q + 2'h1;
			if (access && !done && wait_cnt_q + 2'h1 == `ACCESS_WAIT_CYCLES) begin
				avs_readdata <= avs_read ? {24'h0, rd_byte} : 32'h0;
				avs_response <= mapped ? 2'h0 : 2'h3;
			end
			if (done && avs_write && mapped) begin
				case (avs_address)
				`OFS_PORT_E_PIN_LEVELS, `OFS_PORT_E_OUTPUT_LATCH:
					port_e_output_latch_q <= merge_byte(port_e_output_latch_q,
						avs_writedata[7:0], avs_byteenable[0]); // [RULE15]
				`OFS_PORT_E_DIRECTION:
					port_e_direction_q <= merge_byte(port_e_direction_q, avs_writedata[7:0], avs_byteenable[0]);
				`OFS_PORT_F_PIN_LEVELS, `OFS_PORT_F_OUTPUT_LATCH:
					port_f_output_latch_q <= merge_byte(port_f_output_latch_q,
						avs_writedata[7:0], avs_byteenable[0]); // [RULE3]
				`OFS_PORT_F_DIRECTION:
					port_f_direction_q <= merge_byte(port_f_direction_q, avs_writedata[7:0], avs_byteenable[0]);
				`OFS_ANALOG_CONFIG:
					analog_configuration_q <= merge_byte(analog_configuration_q,
						{2'h0, avs_writedata[5:0]}, avs_byteenable[0]);
				`OFS_COMPARATOR_CONTROL:
					comparator_control_q <= merge_byte(comparator_control_q, avs_writedata[7:0], avs_byteenable[0]);
				`OFS_MUX_CONTROL:
					mux_control_q <= merge_byte(mux_control_q, {1'b0, avs_writedata[6:0]}, avs_byteenable[0]);
				default: ;
				endcase
			end
		end
	end

endmodule // gpio_port_pin_mux_logic

`default_nettype wire

//--- bench/gpio_port_pin_mux_logic_asserts.sv
// Bus timing and pin checks on the port pin block
`timescale 1ns/1ns
`default_nettype none
module port_watch (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	input wire logic [2:0]  port_e_pin_oe,
	input wire logic [7:0]  port_f_pin_oe,
	input wire logic        ext_mem_active,
	input wire logic        ext_mem_read,
	input wire logic [2:0]  ext_mem_addr_data_in,
	input wire logic        capture_unit_two_in
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Write accepted at this edge
	wire logic acc_w = avs_write && !avs_waitrequest;
	////////////////////////////////////////////////////////////////////////////////
	// Answer within two edges, low for one cycle only
	ans_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("no answer to a request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	decode_err_a: assert property (!avs_waitrequest && avs_address > 4'h8 |-> avs_response == 2'h3 && avs_readdata == 32'h0)
		else $error("unmapped index answered wrongly");
	okay_resp_a: assert property (!avs_waitrequest && avs_address <= 4'h8 |-> avs_response == 2'h0 && avs_readdata[31:8] == 24'h0)
		else $error("mapped index answered wrongly");
	data_hold_a: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
		else $error("read data moved between accesses");
	// Pins released right after reset
	reset_float_a: assert property ($rose(resetn) |-> port_f_pin_oe == 8'h00 && port_e_pin_oe == 3'h0 && avs_waitrequest)
		else $error("pins driven after reset");
	// Port F drivers move only after a register write
	f_oe_calm_a: assert property (!$past(acc_w) && !$past(acc_w, 2) |-> $stable(port_f_pin_oe))
		else $error("port F enable moved without a write");
	// Driven pin 7 never feeds the capture input outside external memory cycles
	cap_quiet_a: assert property (!ext_mem_active && !$past(ext_mem_active) && port_e_pin_oe[2] |-> !capture_unit_two_in)
		else $error("capture input fed while pin driven");
	// Memory data input holds outside memory reads
	mem_hold_a: assert property (!$past(ext_mem_read) |-> $stable(ext_mem_addr_data_in))
		else $error("memory data input moved outside a read");
endmodule // port_watch
bind gpio_port_pin_mux_logic port_watch port_watch_i (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .port_e_pin_oe(port_e_pin_oe), .port_f_pin_oe(port_f_pin_oe),
	.ext_mem_active(ext_mem_active), .ext_mem_read(ext_mem_read), .ext_mem_addr_data_in(ext_mem_addr_data_in),
	.capture_unit_two_in(capture_unit_two_in));
`default_nettype wire

//--- bench/pin_world.sv
// Far-side pin model: a driven pin shows the driver, a released pin the outside level
`timescale 1ns/1ns
`default_nettype none
module pin_world #(
	parameter W = 8
) (
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic [W-1:0] ext_level,
	output logic      [W-1:0] pin_in
);
	// Wired level of each pin, outside level changes every test step
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // pin_world
`default_nettype wire

//--- bench/gpio_port_pin_mux_logic_bench.sv
// Self-checking bench for the port pin block with a register model
`timescale 1ns/1ns
`default_nettype none
`include "gpio_port_defs.vh"
module gpio_port_pin_mux_logic_bench;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rdat, r;
	logic        avs_waitrequest, cap_in, mem_act = 1'b0, mem_rd = 1'b0;
	logic [1:0]  avs_response, rs;
	logic [2:0]  e_in, e_out, e_oe, mem_di, e_ext = 3'h0, mem_do = 3'h0;
	logic [7:0]  f_in, f_out, f_oe, fo, f_ext = 8'h0, per = 8'h0;
	logic [7:0]  m [0:8];
	logic [5:0]  x;
	integer      seed = 24265, err_total = 0, n_checks = 0, i, a;
	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	always #10 clk_sys = ~clk_sys;
	initial begin
		#400000;
		err_total++;
		complete_run;
	end
	gpio_port_pin_mux_logic gpio_port_pin_mux_logic_i (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.port_e_pin_in(e_in), .port_e_pin_out(e_out), .port_e_pin_oe(e_oe), .port_f_pin_in(f_in),
		.port_f_pin_out(f_out), .port_f_pin_oe(f_oe), .ext_mem_active(mem_act), .ext_mem_read(mem_rd),
		.ext_mem_addr_data_out(mem_do), .ext_mem_addr_data_in(mem_di), .pwm_one_channel_c(per[0]),
		.pwm_one_channel_b(per[1]), .pwm_one_shutdown(per[2]), .capture_unit_two_out(per[3]),
		.pwm_two_channel_a(per[4]), .pwm_two_shutdown(per[5]), .capture_unit_two_in(cap_in),
		.comparator_one_out(per[6]), .comparator_two_out(per[7]));
	pin_world #(.W(3)) pin_world_e_i (.pin_out(e_out), .pin_oe(e_oe), .ext_level(e_ext), .pin_in(e_in));
	pin_world #(.W(8)) pin_world_f_i (.pin_out(f_out), .pin_oe(f_oe), .ext_level(f_ext), .pin_in(f_in));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// One Avalon access, held until waitrequest is sampled low; model follows writes
	task acc(input logic [3:0] ad, input logic w, input logic [7:0] d);
		integer t;
		t = 0;
		@(posedge clk_sys);
		r = $random(seed);
		avs_address <= ad;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {r[23:0], d};
		do begin
			@(posedge clk_sys);
			t++;
		end while (avs_waitrequest !== 1'b0 && t < 50);
		// A slave that never answers ends the run as a failure
		if (avs_waitrequest !== 1'b0) begin
			err_total++;
			complete_run;
		end
		rdat = avs_readdata;
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (w && ad < 4'h9) m[(ad == 4'h0 || ad == 4'h3) ? ad + 4'h1 : ad] = d;
	endtask
	// Random write under a mask of meaningful bits
	task wr(input logic [3:0] ad, input logic [7:0] mask);
		logic [31:0] v;
		v = $random(seed);
		acc(ad, 1'b1, v[7:0] & mask);
	endtask
	// Read back against the model; pin registers show the wire
	task rd(input logic [3:0] ad);
		logic [7:0] e;
		acc(ad, 1'b0, 8'h0);
		e = (ad > 4'h8) ? 8'h0 : m[ad];
		if (ad == 4'h0) e = {e_in, 5'h0};
		if (ad == 4'h3) e = (m[6][3:0] == 4'hf) ? f_in : {f_in[7], 7'h0};
		chk(32'(rs), (ad > 4'h8) ? 32'h3 : 32'h0);
		chk((ad == 4'h0) ? (rdat & 32'he0) : rdat, 32'(e));
	endtask
	// Expected port E enables and values by priority
	function automatic logic [5:0] exp_e();
		logic [2:0] o, e;
		logic [7:0] c;
		c = m[8];
		e = ~m[2][7:5];
		o = m[1][7:5];
		if (c[2]) o[1:0] = per[1:0];
		if (c[2] && c[3] && per[2]) e[1:0] = 2'h0;
		if (c[4] && !c[1]) o[2] = c[5] ? per[4] : per[3];
		if (c[4] && !c[1] && c[5] && c[6] && per[5]) e[2] = 1'b0;
		if (c[0] && mem_act) e = mem_rd ? 3'h0 : 3'h7;
		if (c[0] && mem_act && !mem_rd) o = mem_do;
		return {e, o & e};
	endfunction
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reset values, then random configurations of both ports
	initial begin
		m = '{8'h0, `RST_LATCH, `RST_DIRECTION, 8'h0, `RST_LATCH, `RST_DIRECTION, `RST_ANALOG_CONFIG,
			`RST_COMPARATOR_CONTROL, `RST_MUX_CONTROL};
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		f_ext <= 8'hff;
		repeat (4) @(posedge clk_sys);
		chk(32'({e_oe, f_oe}), 32'h0);
		for (a = 0; a < 16; a++) rd(a[3:0]);
		for (i = 0; i < 48; i++) begin
			r = $random(seed);
			{mem_rd, mem_act, mem_do, f_ext, e_ext, per} <= r[23:0];
			wr(4'h2, 8'hff);
			wr(i[0] ? 4'h0 : 4'h1, 8'hff);
			wr(4'h8, 8'h7f);
			wr(4'h5, 8'hff);
			wr(i[1] ? 4'h3 : 4'h4, 8'hff);
			if (i[2]) acc(4'h6, 1'b1, `ANALOG_ALL_DIGITAL);
			else wr(4'h6, 8'h07);
			acc(4'h7, 1'b1, i[3] ? `CMP_MODE_OUTPUTS : `CMP_MODE_OFF);
			wr(4'h9, 8'hff);
			repeat (4) @(posedge clk_sys);
			x = exp_e();
			chk(32'({e_oe, e_out & x[5:3]}), 32'(x));
			chk(32'(cap_in), 32'(m[8][4] && !m[8][1] && m[2][7] && e_in[2]));
			if (m[8][0] && mem_act && mem_rd) chk(32'(mem_di), 32'(e_in));
			fo = m[4];
			if (m[7][2:0] == `CMP_MODE_OUTPUTS) fo[2:1] = {per[6], per[7]};
			chk(32'({f_oe, f_out & f_oe}), 32'({~m[5], fo & ~m[5]}));
			for (a = 0; a < 10; a++) rd(a[3:0]);
		end
		complete_run;
	end
endmodule // gpio_port_pin_mux_logic_bench
`default_nettype wire
